//--- verilog/dac_cmd_pkg.sv
// shared constants and types of the converter's serial command port
package dac_cmd_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CORE_CLK_NS = 8;
   localparam int SPIKE_NS    = 10;
   // samples that must agree: (n-1) periods must exceed the spike width
   localparam int SPIKE_CYC   = (SPIKE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS + 1;
   localparam int HS_MAX_KBPS = 3400;

   // ---------------------------------------------------------------
   // byte codes and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] GC_ADDR_BYTE   = 8'h00;
   localparam logic [4:0] HS_CODE_TOP    = 5'h01;
   localparam logic [7:0] GC_RESET_CODE  = 8'h06;
   localparam logic [7:0] GC_WAKEUP_CODE = 8'h0A;
   localparam logic [1:0] CMD_WRITE      = 2'h0;
   localparam logic [1:0] CMD_READ       = 2'h3;
   localparam int         CMD_ADDR_MSB   = 7;
   localparam int         CMD_ADDR_LSB   = 3;
   localparam int         CMD_TYPE_MSB   = 2;
   localparam int         CMD_TYPE_LSB   = 1;

   // ---------------------------------------------------------------
   // bit counter marks, reset values and default address maps
   // ---------------------------------------------------------------
   localparam logic [3:0]  BIT_LAST_DATA = 4'h7;
   localparam logic [3:0]  BIT_BYTE_DONE = 4'h8;
   localparam logic [3:0]  BIT_ACK_DONE  = 4'h9;
   localparam logic [4:0]  PTR_RESET     = 5'h00;
   localparam logic [31:0] VOL_MAP_DEF   = 32'h0000_0703;
   localparam logic [31:0] NV_MAP_DEF    = 32'h0703_0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD  = 3'b010,
      ST_DHI  = 3'b011,
      ST_DLO  = 3'b100,
      ST_RD   = 3'b101,
      ST_GC   = 3'b110,
      ST_WAIT = 3'b111
   } cmd_state_t;

endpackage : dac_cmd_pkg

//--- verilog/scl_filter_if.sv
// link between the command port and its clock spike filter
`timescale 1ns/1ns
interface scl_filter_if;
   logic hs_en;
   logic scl_clean;
   modport filt (input hs_en, output scl_clean);
   modport user (output hs_en, input scl_clean);
endinterface : scl_filter_if

//--- verilog/scl_spike_filter.sv
// serial clock synchroniser with high-speed spike suppression
`timescale 1ns/1ns
module scl_spike_filter
   import dac_cmd_pkg::*;
#(
   parameter int STABLE_CYC = SPIKE_CYC
) (
   input wire logic    core_clk, // core clock
   input wire logic    resetn,   // async reset, active low
   input wire logic    scl_in,   // serial clock pin level
   scl_filter_if.filt  flt       // enable in, clean clock out
);

   if (STABLE_CYC < 1 || STABLE_CYC > 15) begin : g_bad_cyc
      $error("scl_spike_filter: STABLE_CYC out of range");
   end

   logic       scl_s1_ff;
   logic       scl_s2_ff;
   logic       clean_ff;
   logic [3:0] cnt_ff;

   always_ff @(posedge core_clk or negedge resetn) begin : p_sync
      if (!resetn) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
      end else begin
         scl_s1_ff <= scl_in;
         scl_s2_ff <= scl_s1_ff;
      end
   end

   // in high-speed mode a new level must hold for STABLE_CYC samples
   always_ff @(posedge core_clk or negedge resetn) begin : p_filter
      if (!resetn) begin
         clean_ff <= 1'b1;
         cnt_ff   <= 4'h0;
      end else if (scl_s2_ff == clean_ff) begin
         cnt_ff <= 4'h0;
      end else if (!flt.hs_en || cnt_ff == 4'(STABLE_CYC - 1)) begin
         clean_ff <= scl_s2_ff;
         cnt_ff   <= 4'h0;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end

   assign flt.scl_clean = clean_ff;

endmodule : scl_spike_filter

//--- verilog/dac_i2c_slave_command_port.sv
// serial slave command port of a voltage-output converter
//
// Behaviour
// - in high-speed mode, clock spikes under 10 ns are not taken as edges
// - data line slope setting differs between high-speed and normal modes
// - master code 0000 1xxx is not acknowledged but enters high-speed mode
// - high-speed operation lasts until the next Stop
// - command type 00 is a write, 11 a read; general calls handled apart
// - frame lengths: write 38, read 48, last-address read 29, general call 20
// - narrow resolutions take the same 16-bit word and ignore unused bits
// - a first byte of 0x00 is acknowledged; the second byte picks the action
// - Stop or Sr in a data bit aborts the command and drops the partial word
// - volatile write happens on the rising clock of the last data bit
// - nonvolatile programming starts only after a good command and a Stop
// - bad address or command is not acknowledged; only a Start recovers
// - each volatile location's lock bit blocks or allows its writes
// - 5-bit address pointer cleared at reset, kept across Stop and Sr
// - two lowest slave address bits follow the address select pins
// - the port never holds the serial clock low
// - general call wake-up makes the device leave power-down
`timescale 1ns/1ns
module dac_i2c_slave_command_port
   import dac_cmd_pkg::*;
#(
   parameter int          DATA_BITS = 12,
   parameter logic [31:0] VOL_MAP   = VOL_MAP_DEF,
   parameter logic [31:0] NV_MAP    = NV_MAP_DEF
) (
   input  wire logic                 core_clk,                 // core clock, 125 MHz
   input  wire logic                 resetn,                   // power-on/brown-out reset, active low
   input  wire logic                 scl_clk,                  // serial clock pin used as link clock
   input  wire logic                 scl_in,                   // serial clock pin level
   input  wire logic                 sda_in,                   // data pin level
   output logic                      sda_out,                  // data pin drive value
   output logic                      sda_oe,                   // data pin drive enable, high drives
   output logic                      sda_slope_hs,             // data pin slope select, high in HS mode
   input  wire logic                 address_select_pin_upper, // address bit 1 pin
   input  wire logic                 address_select_pin_lower, // address bit 0 pin
   input  wire logic [4:0]           slave_addr_upper,         // stored upper slave address bits
   input  wire logic                 high_voltage_program_pin, // programming voltage present
   input  wire logic                 nv_busy,                  // programming cycle running
   input  wire logic [31:0]          write_lock,               // per-location write lock
   output logic      [4:0]           rd_addr,                  // read address to the store
   input  wire logic [15:0]          rd_data,                  // read word from the store
   output logic                      vol_wr_en,                // volatile write strobe
   output logic      [4:0]           vol_wr_addr,              // volatile write address
   output logic      [DATA_BITS-1:0] vol_wr_data,              // volatile write value
   output logic                      nv_wr_start,              // programming cycle start strobe
   output logic      [4:0]           nv_wr_addr,               // programming address
   output logic      [15:0]          nv_wr_data,               // programming word
   output logic                      gc_reset,                 // general call reset strobe
   output logic                      gc_wakeup                 // general call wake-up strobe
);

   if (DATA_BITS != 8 && DATA_BITS != 10 && DATA_BITS != 12) begin : g_bad_bits
      $error("dac_i2c_slave_command_port: DATA_BITS must be 8, 10 or 12");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic addr_hit(input logic [31:0] map, input logic [4:0] addr);
      addr_hit = map[addr];
   endfunction : addr_hit

   // bit to send next: msb after the ack slot, then downward
   function automatic logic tx_bit(input logic [15:0] word, input logic sel, input logic [3:0] cnt);
      logic [2:0] idx;
      idx    = (cnt == BIT_ACK_DONE) ? 3'h7 : 3'(BIT_LAST_DATA - cnt);
      tx_bit = word[{~sel, idx}];
   endfunction : tx_bit

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   scl_filter_if flt ();

   cmd_state_t  state_ff;
   logic [3:0]  bit_cnt_ff;
   logic [7:0]  rx_ff;
   logic [7:0]  hi_ff;
   logic        nv_flag_ff;
   logic [15:0] rd_word_ff;
   logic        byte_sel_ff;
   logic [4:0]  ptr_ff;
   logic        sda_oe_ff;
   logic        hs_ff;
   logic        nv_pend_ff;
   logic        link_bit_ff;
   logic        link_s1_ff;
   logic        link_s2_ff;
   logic        sda_s1_ff;
   logic        sda_s2_ff;
   logic        sda_prev_ff;
   logic        scl_prev_ff;
   logic [2:0]  pin_s1_ff;
   logic [2:0]  pin_s2_ff;
   logic        vol_wr_en_ff;
   logic [4:0]  vol_wr_addr_ff;
   logic [DATA_BITS-1:0] vol_wr_data_ff;
   logic        nv_wr_start_ff;
   logic [4:0]  nv_wr_addr_ff;
   logic [15:0] nv_wr_data_ff;
   logic        gc_reset_ff;
   logic        gc_wakeup_ff;

   logic        rise_ev;
   logic        fall_ev;
   logic        start_ev;
   logic        stop_ev;
   logic        byte_ev;
   logic        last_bit_ev;
   logic [6:0]  dev_addr;
   logic [4:0]  cmd_addr;
   logic [1:0]  cmd_type;
   logic [15:0] word_w;

   // ---------------------------------------------------------------
   // link clock domain: data bit caught on each serial clock rise
   // ---------------------------------------------------------------
   always_ff @(posedge scl_clk or negedge resetn) begin : p_link
      if (!resetn) begin
         link_bit_ff <= 1'b1;
      end else begin
         link_bit_ff <= sda_in;
      end
   end

   // ---------------------------------------------------------------
   // synchronisers into the core domain
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin : p_sync
      if (!resetn) begin
         link_s1_ff <= 1'b1;
         link_s2_ff <= 1'b1;
         sda_s1_ff  <= 1'b1;
         sda_s2_ff  <= 1'b1;
         pin_s1_ff  <= 3'h0;
         pin_s2_ff  <= 3'h0;
      end else begin
         link_s1_ff <= link_bit_ff;
         link_s2_ff <= link_s1_ff;
         sda_s1_ff  <= sda_in;
         sda_s2_ff  <= sda_s1_ff;
         pin_s1_ff  <= {high_voltage_program_pin, address_select_pin_upper, address_select_pin_lower};
         pin_s2_ff  <= pin_s1_ff;
      end
   end

   scl_spike_filter #(
      .STABLE_CYC (SPIKE_CYC)
   ) u_filter (
      .core_clk (core_clk),
      .resetn   (resetn),
      .scl_in   (scl_in),
      .flt      (flt.filt)
   );

   assign flt.hs_en = hs_ff;

   // ---------------------------------------------------------------
   // bus events
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin : p_edges
      if (!resetn) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_prev_ff <= flt.scl_clean;
         sda_prev_ff <= sda_s2_ff;
      end
   end

   assign rise_ev     = flt.scl_clean & ~scl_prev_ff & (state_ff != ST_IDLE);
   assign fall_ev     = ~flt.scl_clean & scl_prev_ff;
   assign start_ev    = flt.scl_clean & scl_prev_ff & sda_prev_ff & ~sda_s2_ff;
   assign stop_ev     = flt.scl_clean & scl_prev_ff & ~sda_prev_ff & sda_s2_ff;
   assign byte_ev     = fall_ev & (bit_cnt_ff == BIT_BYTE_DONE);
   assign last_bit_ev = rise_ev & (state_ff == ST_DLO) & (bit_cnt_ff == BIT_LAST_DATA);
   assign dev_addr    = {slave_addr_upper, pin_s2_ff[1:0]};
   assign cmd_addr    = rx_ff[CMD_ADDR_MSB:CMD_ADDR_LSB];
   assign cmd_type    = rx_ff[CMD_TYPE_MSB:CMD_TYPE_LSB];
   assign word_w      = {hi_ff, rx_ff[6:0], link_s2_ff};

   // ---------------------------------------------------------------
   // command state machine and data line drive
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin : p_fsm
      if (!resetn) begin
         state_ff    <= ST_IDLE;
         bit_cnt_ff  <= 4'h0;
         rx_ff       <= 8'h00;
         hi_ff       <= 8'h00;
         nv_flag_ff  <= 1'b0;
         rd_word_ff  <= 16'h0000;
         byte_sel_ff <= 1'b0;
         ptr_ff      <= PTR_RESET;
         sda_oe_ff   <= 1'b0;
      end else if (start_ev) begin
         state_ff   <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
         sda_oe_ff  <= 1'b0;
      end else if (stop_ev) begin
         state_ff   <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         sda_oe_ff  <= 1'b0;
      end else if (rise_ev && bit_cnt_ff != BIT_ACK_DONE) begin
         if (bit_cnt_ff != BIT_BYTE_DONE) begin
            rx_ff <= {rx_ff[6:0], link_s2_ff};
         end
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
         if (state_ff == ST_RD && bit_cnt_ff == BIT_BYTE_DONE) begin
            if (link_s2_ff) begin
               state_ff <= ST_WAIT;
            end else if (byte_sel_ff) begin
               rd_word_ff  <= rd_data;
               byte_sel_ff <= 1'b0;
            end else begin
               byte_sel_ff <= 1'b1;
            end
         end
      end else if (byte_ev) begin
         sda_oe_ff <= 1'b0;
         case (state_ff)
            ST_ADDR: begin
               if (rx_ff == GC_ADDR_BYTE) begin
                  sda_oe_ff <= 1'b1;
                  state_ff  <= ST_GC;
               end else if (rx_ff[7:3] == HS_CODE_TOP) begin
                  state_ff <= ST_WAIT;
               end else if (rx_ff[7:1] == dev_addr) begin
                  sda_oe_ff <= 1'b1;
                  if (rx_ff[0]) begin
                     state_ff    <= ST_RD;
                     rd_word_ff  <= rd_data;
                     byte_sel_ff <= 1'b1; // address ack slot flips it to the high byte
                  end else begin
                     state_ff <= ST_CMD;
                  end
               end else begin
                  state_ff <= ST_WAIT;
               end
            end
            ST_CMD: begin
               state_ff <= ST_WAIT;
               if (nv_pend_ff) begin
                  state_ff <= ST_WAIT;
               end else if (cmd_type == CMD_WRITE && addr_hit(VOL_MAP, cmd_addr)) begin
                  sda_oe_ff  <= 1'b1;
                  ptr_ff     <= cmd_addr;
                  nv_flag_ff <= 1'b0;
                  state_ff   <= ST_DHI;
               end else if (cmd_type == CMD_WRITE && addr_hit(NV_MAP, cmd_addr) && !nv_busy) begin
                  sda_oe_ff  <= 1'b1;
                  ptr_ff     <= cmd_addr;
                  nv_flag_ff <= 1'b1;
                  state_ff   <= ST_DHI;
               end else if (cmd_type == CMD_READ && (addr_hit(VOL_MAP, cmd_addr) ||
                            (addr_hit(NV_MAP, cmd_addr) && !nv_busy))) begin
                  sda_oe_ff <= 1'b1;
                  ptr_ff    <= cmd_addr;
               end
            end
            ST_DHI: begin
               sda_oe_ff <= 1'b1;
               hi_ff     <= rx_ff;
               state_ff  <= ST_DLO;
            end
            ST_DLO: begin
               sda_oe_ff <= 1'b1;
               state_ff  <= ST_CMD;
            end
            ST_GC: begin
               state_ff <= ST_WAIT;
               if (rx_ff == GC_RESET_CODE) begin
                  sda_oe_ff <= 1'b1;
                  ptr_ff    <= PTR_RESET;
               end else if (rx_ff == GC_WAKEUP_CODE) begin
                  sda_oe_ff <= 1'b1;
               end
            end
            ST_RD: begin
               sda_oe_ff <= 1'b0;
            end
            default: begin
               state_ff <= ST_WAIT;
            end
         endcase
      end else if (fall_ev && bit_cnt_ff == BIT_ACK_DONE) begin
         bit_cnt_ff <= 4'h0;
         sda_oe_ff  <= (state_ff == ST_RD) && !tx_bit(rd_word_ff, byte_sel_ff, bit_cnt_ff);
      end else if (fall_ev && state_ff == ST_RD) begin
         sda_oe_ff <= !tx_bit(rd_word_ff, byte_sel_ff, bit_cnt_ff);
      end
   end

   // ---------------------------------------------------------------
   // high-speed mode
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin : p_hs
      if (!resetn) begin
         hs_ff <= 1'b0;
      end else if (stop_ev) begin
         hs_ff <= 1'b0;
      end else if (byte_ev && state_ff == ST_ADDR && rx_ff[7:3] == HS_CODE_TOP) begin
         hs_ff <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // write and general call strobes
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin : p_strobe
      if (!resetn) begin
         vol_wr_en_ff   <= 1'b0;
         vol_wr_addr_ff <= 5'h00;
         vol_wr_data_ff <= '0;
         nv_wr_start_ff <= 1'b0;
         nv_wr_addr_ff  <= 5'h00;
         nv_wr_data_ff  <= 16'h0000;
         nv_pend_ff     <= 1'b0;
         gc_reset_ff    <= 1'b0;
         gc_wakeup_ff   <= 1'b0;
      end else begin
         vol_wr_en_ff   <= 1'b0;
         nv_wr_start_ff <= 1'b0;
         gc_reset_ff    <= byte_ev && state_ff == ST_GC && rx_ff == GC_RESET_CODE;
         gc_wakeup_ff   <= byte_ev && state_ff == ST_GC && rx_ff == GC_WAKEUP_CODE;
         if (last_bit_ev && !nv_flag_ff) begin
            vol_wr_en_ff   <= !write_lock[ptr_ff];
            vol_wr_addr_ff <= ptr_ff;
            vol_wr_data_ff <= word_w[DATA_BITS-1:0];
         end
         if (last_bit_ev && nv_flag_ff && pin_s2_ff[2]) begin
            nv_pend_ff    <= 1'b1;
            nv_wr_addr_ff <= ptr_ff;
            nv_wr_data_ff <= word_w;
         end else if (start_ev || (byte_ev && state_ff == ST_CMD)) begin
            nv_pend_ff <= 1'b0;
         end else if (stop_ev && nv_pend_ff) begin
            nv_pend_ff     <= 1'b0;
            nv_wr_start_ff <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs; the clock line is never driven
   // ---------------------------------------------------------------
   assign sda_out      = 1'b0;
   assign sda_oe       = sda_oe_ff;
   assign sda_slope_hs = hs_ff;
   assign rd_addr      = ptr_ff;
   assign vol_wr_en    = vol_wr_en_ff;
   assign vol_wr_addr  = vol_wr_addr_ff;
   assign vol_wr_data  = vol_wr_data_ff;
   assign nv_wr_start  = nv_wr_start_ff;
   assign nv_wr_addr   = nv_wr_addr_ff;
   assign nv_wr_data   = nv_wr_data_ff;
   assign gc_reset     = gc_reset_ff;
   assign gc_wakeup    = gc_wakeup_ff;

endmodule : dac_i2c_slave_command_port

//--- tb/dac_cmd_port_chk.sv
// assertions on the command port's pins and strobes
`timescale 1ns/1ns
module dac_cmd_port_chk (
   input wire logic        core_clk,                 // core clock
   input wire logic        resetn,                   // reset, active low
   input wire logic        scl_in,                   // clock pin
   input wire logic        sda_in,                   // data pin
   input wire logic        sda_oe,                   // data drive
   input wire logic        sda_slope_hs,             // hs slope
   input wire logic [31:0] write_lock,               // locks
   input wire logic [4:0]  rd_addr,                  // pointer
   input wire logic        vol_wr_en,                // volatile strobe
   input wire logic [4:0]  vol_wr_addr,              // volatile address
   input wire logic        nv_wr_start,              // nv strobe
   input wire logic        gc_reset,                 // gc reset strobe
   input wire logic        gc_wakeup,                // gc wake strobe
   input wire logic        high_voltage_program_pin  // hv pin
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_ptr_rst; $rose(resetn) |-> rd_addr == 5'h00 && !sda_oe; endproperty
   a_ptr_rst: assert property (p_ptr_rst) else $error("pointer or drive set after reset");
   property p_vol_rise; vol_wr_en |-> scl_in; endproperty
   a_vol_rise: assert property (p_vol_rise) else $error("volatile write off the clock high");
   property p_vol_lock; vol_wr_en |-> !write_lock[vol_wr_addr] ##1 !vol_wr_en; endproperty
   a_vol_lock: assert property (p_vol_lock) else $error("write to locked location");
   property p_nv_stop; nv_wr_start |-> scl_in && sda_in && high_voltage_program_pin; endproperty
   a_nv_stop: assert property (p_nv_stop) else $error("programming start not after stop");
   property p_gc_rst; gc_reset |-> !gc_wakeup ##[1:3] rd_addr == 5'h00; endproperty
   a_gc_rst: assert property (p_gc_rst) else $error("general reset kept the pointer");
   property p_gc_wk; gc_wakeup |=> !gc_wakeup && !gc_reset; endproperty
   a_gc_wk: assert property (p_gc_wk) else $error("wake-up strobe too long");
   property p_hs_end; $fell(sda_slope_hs) |-> scl_in && sda_in; endproperty
   a_hs_end: assert property (p_hs_end) else $error("fast mode left outside stop");
   property p_hs_noack; $rose(sda_slope_hs) |-> !sda_oe [*8]; endproperty
   a_hs_noack: assert property (p_hs_noack) else $error("master code acknowledged");
endmodule : dac_cmd_port_chk
bind dac_i2c_slave_command_port dac_cmd_port_chk u_chk (
   .core_clk(core_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
   .sda_slope_hs(sda_slope_hs), .write_lock(write_lock), .rd_addr(rd_addr), .vol_wr_en(vol_wr_en),
   .vol_wr_addr(vol_wr_addr), .nv_wr_start(nv_wr_start), .gc_reset(gc_reset), .gc_wakeup(gc_wakeup),
   .high_voltage_program_pin(high_voltage_program_pin));

//--- tb/i2c_master_model.sv
// bus master model driving the serial clock and data lines
`timescale 1ns/1ns
module i2c_master_model (
   output logic      scl,    // serial clock, idle high
   output logic      sda_lo, // pulls data line low when high
   input  wire logic sda     // resolved data line
);
   initial begin
      scl = 1'b1;
      sda_lo = 1'b0;
   end
   // one 125 ns bit: data set late in the low phase, past the port's clock filter lag
   task automatic clk_bit(input logic b, output logic r);
      #36 sda_lo = ~b;
      #26 scl = 1'b1;
      #31 r = sda;
      #32 scl = 1'b0;
   endtask : clk_bit
   task automatic start;
      if (!scl) begin
         #36 sda_lo = 1'b0;
         #26 scl = 1'b1;
      end
      #31 sda_lo = 1'b1;
      #32 scl = 1'b0;
   endtask : start
   task automatic stop;
      #36 sda_lo = 1'b1;
      #26 scl = 1'b1;
      #31 sda_lo = 1'b0;
      #32;
   endtask : stop
   task automatic tx(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask : tx
   task automatic rx(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, r);
         d[i] = r;
      end
      clk_bit(~more, r);
   endtask : rx
endmodule : i2c_master_model

//--- tb/dac_i2c_slave_command_port_tb_top.sv
// self-checking bench for the converter command port
`timescale 1ns/1ns
module dac_i2c_slave_command_port_tb_top;
   import dac_cmd_pkg::*;
   logic        core_clk, resetn, scl, m_lo, sda, sda_out, sda_oe, slope, hv, busy;
   logic        vol_en, nv_st, gc_r, gc_w, ack, r;
   logic [31:0] lock;
   logic [4:0]  rd_addr, v_addr, n_addr;
   logic [15:0] rd_data, n_data;
   logic [11:0] v_data;
   logic [7:0]  hi, lo;
   int          n_mismatch, cmp_count, n_vol, n_nv, n_gr, n_gw;
   assign sda = (sda_oe ? sda_out : 1'b1) & ~m_lo;
   assign rd_data = {3'h5, rd_addr, 8'h3C};
   i2c_master_model m (.scl(scl), .sda_lo(m_lo), .sda(sda));
   dac_i2c_slave_command_port dut (
      .core_clk(core_clk), .resetn(resetn), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .sda_slope_hs(slope),
      .address_select_pin_upper(1'b0), .address_select_pin_lower(1'b1), .slave_addr_upper(5'h18),
      .high_voltage_program_pin(hv), .nv_busy(busy), .write_lock(lock), .rd_addr(rd_addr),
      .rd_data(rd_data), .vol_wr_en(vol_en), .vol_wr_addr(v_addr), .vol_wr_data(v_data),
      .nv_wr_start(nv_st), .nv_wr_addr(n_addr), .nv_wr_data(n_data), .gc_reset(gc_r),
      .gc_wakeup(gc_w));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (vol_en) n_vol++;
      if (nv_st) n_nv++;
      if (gc_r) n_gr++;
      if (gc_w) n_gw++;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic tack(input logic [7:0] d, input logic e);
      m.tx(d, ack);
      chk({15'h0, ack}, {15'h0, e});
   endtask : tack
   task automatic t_write;
      n_vol = 0;
      m.start();
      tack(8'hC2, 1'b1);
      tack(8'h00, 1'b1);
      tack(8'h01, 1'b1);
      tack(8'h23, 1'b1);
      chk(16'(n_vol), 16'h0001);
      chk({4'h0, v_data}, 16'h0123);
      chk({11'h0, v_addr}, 16'h0000);
      tack(8'h40, 1'b1);
      tack(8'h0A, 1'b1);
      tack(8'hBC, 1'b1);
      chk(16'(n_vol), 16'h0002);
      chk({4'h0, v_data}, 16'h0ABC);
      m.stop();
      @(negedge core_clk) lock[9] = 1'b1;
      m.start();
      tack(8'hC2, 1'b1);
      tack(8'h48, 1'b1);
      m.tx(8'h0F, ack);
      m.tx(8'hFF, ack);
      chk(16'(n_vol), 16'h0002);
      tack(8'h00, 1'b1);
      tack(8'h07, 1'b1);
      repeat (4) m.clk_bit(1'b0, r);
      m.stop();
      chk(16'(n_vol), 16'h0002);
      @(negedge core_clk) lock[9] = 1'b0;
      $display("test write done");
   endtask : t_write
   task automatic t_refuse;
      m.start();
      tack(8'hC2, 1'b1);
      tack(8'h02, 1'b0);
      tack(8'h00, 1'b0);
      m.start();
      tack(8'hC2, 1'b1);
      tack(8'h00, 1'b1);
      m.stop();
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_read;
      m.start();
      tack(8'hC2, 1'b1);
      tack(8'h46, 1'b1);
      m.start();
      tack(8'hC3, 1'b1);
      m.rx(1'b1, hi);
      m.rx(1'b0, lo);
      chk({hi, lo}, {3'h5, 5'h08, 8'h3C});
      m.stop();
      chk({11'h0, rd_addr}, 16'h0008);
      $display("test read done");
   endtask : t_read
   task automatic t_gc;
      n_gr = 0;
      n_gw = 0;
      m.start();
      tack(GC_ADDR_BYTE, 1'b1);
      tack(GC_RESET_CODE, 1'b1);
      m.stop();
      chk(16'(n_gr), 16'h0001);
      chk({11'h0, rd_addr}, 16'h0000);
      m.start();
      tack(GC_ADDR_BYTE, 1'b1);
      tack(GC_WAKEUP_CODE, 1'b1);
      m.stop();
      chk(16'(n_gw), 16'h0001);
      m.start();
      tack(GC_ADDR_BYTE, 1'b1);
      tack(8'h04, 1'b0);
      m.stop();
      $display("test general call done");
   endtask : t_gc
   task automatic t_hs;
      m.start();
      tack(8'h09, 1'b0);
      chk({15'h0, slope}, 16'h0001);
      m.start();
      tack(8'hC2, 1'b1);
      m.stop();
      repeat (12) @(negedge core_clk);
      chk({15'h0, slope}, 16'h0000);
      $display("test high speed done");
   endtask : t_hs
   task automatic t_nv;
      n_nv = 0;
      hv = 1'b1;
      m.start();
      tack(8'hC2, 1'b1);
      tack(8'h80, 1'b1);
      tack(8'h12, 1'b1);
      tack(8'h34, 1'b1);
      chk(16'(n_nv), 16'h0000);
      m.stop();
      repeat (12) @(negedge core_clk);
      chk(16'(n_nv), 16'h0001);
      chk(n_data, 16'h1234);
      chk({11'h0, n_addr}, 16'h0010);
      busy = 1'b1;
      m.start();
      tack(8'hC2, 1'b1);
      tack(8'h80, 1'b0);
      m.stop();
      @(negedge core_clk) busy = 1'b0;
      hv = 1'b0;
      $display("test nonvolatile done");
   endtask : t_nv
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   initial begin
      resetn = 1'b0;
      lock = 32'h0;
      hv = 1'b0;
      busy = 1'b0;
      repeat (4) @(negedge core_clk);
      resetn = 1'b1;
      repeat (4) @(negedge core_clk);
      t_write();
      t_refuse();
      t_read();
      t_gc();
      t_hs();
      t_nv();
      end_of_test();
   end
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end
endmodule : dac_i2c_slave_command_port_tb_top
